// File: rtl/rtc_control.sv
`default_nettype none
// Operation
// R01 - command is proportional gain times error plus integral gain times summed error
// R02 - error is target minus measured in heating, measured minus target in cooling
// R03 - proportional gain equals one hundred divided by band width
// R04 - reset period equals proportional gain over integral gain
// R05 - error equal to band width gives full command from proportional part
// R06 - integral adds one proportional contribution per reset period at constant error
// R07 - pwm runs fixed cycles, on for time proportional to command
// R08 - target change aborts cycle, recomputes command, starts fresh cycle
// R09 - configurer should pick 15-20 minute cycles, 10-15 for air systems
// R10 - up to three fan stages, each one speed with own hysteresis loop
// R11 - all other speeds off before a new speed is switched on
// R12 - heating speed one on below target-thr-hyst, off at target-thr or higher
// R13 - heating speed two on below target-thr-hyst, off at target-thr or speed three
// R14 - heating speed three on below target-thr-hyst, off at target-thr
// R15 - one fan hysteresis for all stages, heating and cooling alike
// R16 - heating valve opens below target-hyst, closes at target with speed one
// R17 - commands sent to actuator on change or periodically
// R18 - cooling speeds on above target+thr+hyst, off at target+thr
// R19 - staged speed percent only 0, 33,3, 66,7, 100
// R20 - command limited to zero to one hundred percent
// R21 - after reset outputs off and integral clear until first sample
module rtc_control #(
  parameter int FAN_STAGES = 3,
  parameter int SEND_PERIOD_CYCLES = 1_200_000_000,
  parameter int CYCLES_PER_SECOND = rtc_pkg::CLOCK_HZ
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_cooling,
  input wire logic i_sample_valid,
  input wire logic signed [rtc_pkg::TEMP_W-1:0] i_measured,
  input wire logic signed [rtc_pkg::TEMP_W-1:0] i_target,
  input wire logic [15:0] i_band_width_kelvin,       // 1/100 K
  input wire logic [15:0] i_reset_period_minutes,
  input wire logic [15:0] i_cycle_minutes,
  input wire logic signed [rtc_pkg::TEMP_W-1:0] i_fan_threshold1,
  input wire logic signed [rtc_pkg::TEMP_W-1:0] i_fan_threshold2,
  input wire logic signed [rtc_pkg::TEMP_W-1:0] i_fan_threshold3,
  input wire logic signed [rtc_pkg::TEMP_W-1:0] i_fan_hysteresis,
  input wire logic signed [rtc_pkg::TEMP_W-1:0] i_valve_hysteresis,
  output logic [rtc_pkg::PCT_W-1:0] o_command,
  output logic o_pwm,
  output logic o_speed1,
  output logic o_speed2,
  output logic o_speed3,
  output logic [rtc_pkg::PCT_W-1:0] o_speed_percent,
  output logic o_valve,
  output logic o_send
);
  localparam int DW = rtc_pkg::TEMP_W + 1;
  localparam int AW = rtc_pkg::ACC_W;

  // ==========================================
  // error and sampling
  logic started_reg;
  logic signed [DW-1:0] error_reg;
  logic signed [rtc_pkg::TEMP_W-1:0] target_last_reg;
  logic target_changed;
  logic signed [DW-1:0] error_now;

  always_comb begin
    if (i_cooling) begin
      error_now = DW'(i_measured) - DW'(i_target); // R02
    end else begin
      error_now = DW'(i_target) - DW'(i_measured); // R02
    end
  end

  assign target_changed = started_reg && (i_target != target_last_reg);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      started_reg <= 1'b0;
      error_reg <= '0;
    end else if (i_sample_valid) begin
      started_reg <= 1'b1; // R21
      error_reg <= error_now;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      target_last_reg <= '0;
    end else begin
      target_last_reg <= i_target;
    end
  end

  // ==========================================
  // one second tick
  logic [31:0] sec_cnt_reg;
  logic sec_tick;
  assign sec_tick = (sec_cnt_reg == 32'(CYCLES_PER_SECOND - 1));
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sec_cnt_reg <= '0;
    end else if (sec_tick) begin
      sec_cnt_reg <= '0;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'h1;
    end
  end

  // ==========================================
  // pi law: pct = 100*e/bw + 100*sum(e*dt)/(bw*ti*60)
  logic signed [AW-1:0] integ_reg;
  logic signed [AW-1:0] prop_pct;
  logic signed [AW-1:0] integ_pct;
  logic signed [AW-1:0] total_pct;
  logic signed [AW-1:0] bw_s;
  logic signed [AW-1:0] ti_sec;

  assign bw_s = (i_band_width_kelvin == 16'h0) ? AW'(1) : AW'(i_band_width_kelvin);
  assign ti_sec = (i_reset_period_minutes == 16'h0) ? AW'(1) :
                  AW'(i_reset_period_minutes) * AW'(rtc_pkg::SECONDS_PER_MINUTE); // R04
  assign prop_pct = (AW'(error_reg) * AW'(rtc_pkg::GAIN_SCALE)) / bw_s; // R03 R05
  assign integ_pct = (integ_reg * AW'(rtc_pkg::GAIN_SCALE)) / (bw_s * ti_sec); // R06
  assign total_pct = prop_pct + integ_pct; // R01

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      integ_reg <= '0; // R21
    end else if (started_reg && sec_tick) begin
      // anti windup: stop integrating once saturated in the same direction
      if (!((total_pct >= $signed(AW'(rtc_pkg::PCT_FULL)) && error_reg > 0) ||
            (total_pct <= 0 && error_reg < 0))) begin
        integ_reg <= integ_reg + AW'(error_reg); // R01
      end
    end
  end

  logic [rtc_pkg::PCT_W-1:0] command_reg;
  logic [rtc_pkg::PCT_W-1:0] command_next;
  always_comb begin
    if (total_pct <= 0) begin
      command_next = rtc_pkg::PCT_ZERO; // R20
    end else if (total_pct >= AW'(rtc_pkg::PCT_FULL)) begin
      command_next = rtc_pkg::PCT_FULL; // R20
    end else begin
      command_next = total_pct[rtc_pkg::PCT_W-1:0];
    end
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      command_reg <= rtc_pkg::PCT_ZERO;
    end else if (started_reg) begin
      command_reg <= command_next;
    end
  end
  assign o_command = command_reg;

  // ==========================================
  // pwm: cycle split into 100 steps
  logic [31:0] step_len;
  logic [31:0] step_cnt_reg;
  logic [7:0] step_reg;
  logic [rtc_pkg::PCT_W-1:0] duty_reg;
  logic pwm_reg;
  logic step_end;
  assign step_len = (i_cycle_minutes == 16'h0) ? 32'h1 :
                    32'((64'(i_cycle_minutes) * 64'(rtc_pkg::SECONDS_PER_MINUTE)
                    * 64'(CYCLES_PER_SECOND)) / 64'(rtc_pkg::PWM_STEPS));
  assign step_end = (step_cnt_reg >= step_len - 32'h1);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      step_cnt_reg <= '0;
      step_reg <= '0;
      duty_reg <= rtc_pkg::PCT_ZERO;
      pwm_reg <= 1'b0; // R21
    end else if (!started_reg) begin
      pwm_reg <= 1'b0;
    end else if (target_changed) begin
      step_cnt_reg <= '0; // R08
      step_reg <= '0; // R08
      duty_reg <= command_next; // R08
      pwm_reg <= (command_next != rtc_pkg::PCT_ZERO); // R08
    end else if (step_end) begin
      step_cnt_reg <= '0;
      if (step_reg == 8'(rtc_pkg::PWM_STEPS - 1)) begin
        step_reg <= '0;
        duty_reg <= command_reg; // R07
        pwm_reg <= (command_reg != rtc_pkg::PCT_ZERO);
      end else begin
        step_reg <= step_reg + 8'h1;
        pwm_reg <= ((step_reg + 8'h1) < duty_reg); // R07
      end
    end else begin
      step_cnt_reg <= step_cnt_reg + 32'h1;
    end
  end
  assign o_pwm = pwm_reg;

  // ==========================================
  // fan stages and valve on demand = error
  logic [2:0] want;
  logic signed [DW-1:0] thr [3];
  logic want_valve;
  assign thr[0] = DW'(i_fan_threshold1);
  assign thr[1] = DW'(i_fan_threshold2);
  assign thr[2] = DW'(i_fan_threshold3);

  for (genvar g = 0; g < 3; g++) begin : g_stage
    rtc_stage #(.W(DW)) u_stage (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_run(started_reg && (g < FAN_STAGES)), // R10
      .i_demand(error_reg), // R12 R13 R14 R18
      .i_threshold(thr[g]),
      .i_hysteresis(DW'(i_fan_hysteresis)), // R15
      .o_want(want[g])
    );
  end

  rtc_stage #(.W(DW)) u_valve (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_run(started_reg),
    .i_demand(error_reg),
    .i_threshold('0),
    .i_hysteresis(DW'(i_valve_hysteresis)),
    .o_want(want_valve) // R16
  );

  rtc_pkg::rtc_fan_e fan_target;
  always_comb begin
    if (want[2]) begin
      fan_target = rtc_pkg::RTC_FAN_3; // R13
    end else if (want[1]) begin
      fan_target = rtc_pkg::RTC_FAN_2; // R12
    end else if (want[0] && want_valve) begin
      fan_target = rtc_pkg::RTC_FAN_1; // R16
    end else begin
      fan_target = rtc_pkg::RTC_FAN_OFF;
    end
  end

  rtc_pkg::rtc_fan_e fan_reg;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fan_reg <= rtc_pkg::RTC_FAN_OFF; // R21
    end else if (fan_reg != fan_target && fan_reg != rtc_pkg::RTC_FAN_OFF) begin
      fan_reg <= rtc_pkg::RTC_FAN_OFF; // R11
    end else begin
      fan_reg <= fan_target;
    end
  end

  logic valve_reg;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      valve_reg <= 1'b0; // R21
    end else begin
      valve_reg <= want_valve; // R16
    end
  end

  logic [rtc_pkg::PCT_W-1:0] spct_reg;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      spct_reg <= rtc_pkg::PCT_ZERO;
    end else begin
      case (fan_reg)
        rtc_pkg::RTC_FAN_1: spct_reg <= rtc_pkg::PCT_SPEED1; // R19
        rtc_pkg::RTC_FAN_2: spct_reg <= rtc_pkg::PCT_SPEED2; // R19
        rtc_pkg::RTC_FAN_3: spct_reg <= rtc_pkg::PCT_FULL; // R19
        default: spct_reg <= rtc_pkg::PCT_ZERO;
      endcase
    end
  end

  assign o_speed1 = (fan_reg == rtc_pkg::RTC_FAN_1);
  assign o_speed2 = (fan_reg == rtc_pkg::RTC_FAN_2);
  assign o_speed3 = (fan_reg == rtc_pkg::RTC_FAN_3);
  assign o_speed_percent = spct_reg;
  assign o_valve = valve_reg;

  // ==========================================
  // send strobe on change or period
  logic [31:0] send_cnt_reg;
  logic [rtc_pkg::PCT_W-1:0] sent_cmd_reg;
  logic [4:0] sent_bits_reg;
  logic [4:0] bits_now;
  logic send_reg;
  assign bits_now = {o_pwm, o_speed1, o_speed2, o_speed3, o_valve};
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      send_cnt_reg <= '0;
      sent_cmd_reg <= rtc_pkg::PCT_ZERO;
      sent_bits_reg <= '0;
      send_reg <= 1'b0;
    end else if (started_reg && (command_reg != sent_cmd_reg || bits_now != sent_bits_reg ||
                 send_cnt_reg >= 32'(SEND_PERIOD_CYCLES - 1))) begin
      send_cnt_reg <= '0;
      sent_cmd_reg <= command_reg; // R17
      sent_bits_reg <= bits_now;
      send_reg <= 1'b1; // R17
    end else begin
      send_cnt_reg <= send_cnt_reg + 32'h1;
      send_reg <= 1'b0;
    end
  end
  assign o_send = send_reg;
endmodule : rtc_control
`default_nettype wire

// File: common/rtc_pkg.sv
`default_nettype none
package rtc_pkg;
  // ==========================================
  // temperature and command formats
  localparam int TEMP_W = 16;          // signed, 1/100 K per lsb
  localparam int PCT_W = 8;            // command percent 0..100
  localparam int ACC_W = 48;
  localparam int GAIN_SCALE = 100;     // gain numerator, percent per band
  localparam logic [PCT_W-1:0] PCT_FULL = 8'h64;
  localparam logic [PCT_W-1:0] PCT_ZERO = 8'h00;
  localparam logic [PCT_W-1:0] PCT_SPEED1 = 8'h21;  // 33,3 % rounded
  localparam logic [PCT_W-1:0] PCT_SPEED2 = 8'h43;  // 66,7 % rounded
  // ==========================================
  // timing
  localparam int CLOCK_HZ = 20_000_000;
  localparam int SECONDS_PER_MINUTE = 60;
  localparam int PWM_STEPS = 100;
  // ==========================================
  // fan stage codes
  typedef enum logic [1:0] {
    RTC_FAN_OFF,
    RTC_FAN_1,
    RTC_FAN_2,
    RTC_FAN_3
  } rtc_fan_e;
endpackage : rtc_pkg
`default_nettype wire

// File: rtl/rtc_stage.sv
`default_nettype none
// single hysteresis loop on a signed demand value
module rtc_stage #(
  parameter int W = 17
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic signed [W-1:0] i_demand,
  input wire logic signed [W-1:0] i_threshold,
  input wire logic signed [W-1:0] i_hysteresis,
  output logic o_want
);
  logic want_reg;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      want_reg <= 1'b0;
    end else if (!i_run) begin
      want_reg <= 1'b0;
    end else if (i_demand > i_threshold + i_hysteresis) begin
      want_reg <= 1'b1;
    end else if (i_demand <= i_threshold) begin
      want_reg <= 1'b0;
    end
  end
  assign o_want = want_reg;
endmodule : rtc_stage
`default_nettype wire

// File: sim/rtc_control_monitor.sv
`default_nettype none
module rtc_control_monitor (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_sample_valid,
  input wire logic [rtc_pkg::PCT_W-1:0] o_command,
  input wire logic o_pwm,
  input wire logic o_speed1,
  input wire logic o_speed2,
  input wire logic o_speed3,
  input wire logic [rtc_pkg::PCT_W-1:0] o_speed_percent,
  input wire logic o_valve,
  input wire logic o_send
);
  // ========
  // helpers
  logic seen_reg;
  logic [2:0] spd;
  logic [rtc_pkg::PCT_W-1:0] pct;
  assign spd = {o_speed3, o_speed2, o_speed1};
  assign pct = o_speed3 ? rtc_pkg::PCT_FULL : o_speed2 ? rtc_pkg::PCT_SPEED2 :
    o_speed1 ? rtc_pkg::PCT_SPEED1 : rtc_pkg::PCT_ZERO;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      seen_reg <= 1'b0;
    end else if (i_sample_valid) begin
      seen_reg <= 1'b1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ========
  // assertions
  a_idle_before_sample: assert property (!seen_reg |-> {o_command, o_pwm, spd, o_valve, o_speed_percent, o_send} == '0)
    else $error("output active before first sample");
  a_speeds_exclusive: assert property ($onehot0(spd))
    else $error("two fan speeds at once");
  a_change_via_off: assert property ($changed(spd) && spd != 3'b000 |-> $past(spd) == 3'b000)
    else $error("speed changed without off step");
  a_command_range: assert property (o_command <= rtc_pkg::PCT_FULL)
    else $error("command above full scale");
  a_percent_follows: assert property (##1 o_speed_percent == $past(pct))
    else $error("speed percent not matching speed");
  a_valve_takes_speed1: assert property ($fell(o_valve) |-> !o_speed1)
    else $error("speed one left on with valve shut");
  a_send_on_change: assert property (!$stable(o_command) |=> o_send)
    else $error("command change not sent");
  a_pwm_off_zero: assert property ($rose(o_pwm) |-> o_command != rtc_pkg::PCT_ZERO || $past(o_command) != rtc_pkg::PCT_ZERO)
    else $error("pwm on with zero command");
  c_speed3: cover property (spd == 3'b100);
  c_pwm_on: cover property ($rose(o_pwm));
  c_valve_off: cover property ($fell(o_valve));
endmodule : rtc_control_monitor
bind rtc_control rtc_control_monitor mon_u (.i_clock(i_clock), .i_rst(i_rst), .i_sample_valid(i_sample_valid),
  .o_command(o_command), .o_pwm(o_pwm), .o_speed1(o_speed1), .o_speed2(o_speed2), .o_speed3(o_speed3),
  .o_speed_percent(o_speed_percent), .o_valve(o_valve), .o_send(o_send));
`default_nettype wire

// File: sim/rtc_actuator_model.sv
`default_nettype none
module rtc_actuator_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_send,
  input wire logic [rtc_pkg::PCT_W-1:0] i_command,
  input wire logic [2:0] i_speeds,
  output logic [rtc_pkg::PCT_W-1:0] o_last_command,
  output logic [2:0] o_last_speeds
);
  // ========
  // telegram capture
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_last_command <= '0;
      o_last_speeds <= '0;
    end else if (i_send) begin
      o_last_command <= i_command;
      o_last_speeds <= i_speeds;
    end
  end
endmodule : rtc_actuator_model
`default_nettype wire

// File: sim/rtc_control_tb.sv
`default_nettype none
module rtc_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic cool = 1'b0;
  logic sv = 1'b0;
  logic signed [15:0] meas = '0;
  logic signed [15:0] tgt = '0;
  logic [15:0] ti = 16'hffff;
  logic [15:0] bw = 16'h0190;
  logic [15:0] cyc = 16'h000f;
  logic signed [15:0] fhys = 16'h001e;
  logic signed [15:0] vhys = 16'h001e;
  logic [7:0] cmd, pct, last_cmd;
  logic pwm, s1, s2, s3, valve, send;
  logic [2:0] last_spd;
  int n_errors = 0;
  int n_checks = 0;
  int cnt;
  int pi_meas[5] = '{1800, 1600, 1000, 2200, 1800};
  int pi_exp[5] = '{50, 100, 100, 50, 0};
  bit [4:0] pi_cool = 5'b11000;
  int fan_d[7] = '{50, 150, 250, 150, 50, -10, 20};
  logic [2:0] fan_s[7] = '{3'b001, 3'b010, 3'b100, 3'b010, 3'b001, 3'b000, 3'b000};
  logic [7:0] fan_p[7] = '{8'h21, 8'h43, 8'h64, 8'h43, 8'h21, 8'h00, 8'h00};
  bit [6:0] fan_v = 7'b0011111;
  always #25 i_clock = ~i_clock;
  rtc_control #(.CYCLES_PER_SECOND(1), .SEND_PERIOD_CYCLES(1000)) dut_u (.i_clock(i_clock), .i_rst(i_rst),
    .i_cooling(cool), .i_sample_valid(sv), .i_measured(meas), .i_target(tgt), .i_band_width_kelvin(bw),
    .i_reset_period_minutes(ti), .i_cycle_minutes(cyc), .i_fan_threshold1(16'h0000),
    .i_fan_threshold2(16'h0064), .i_fan_threshold3(16'h00c8), .i_fan_hysteresis(fhys),
    .i_valve_hysteresis(vhys), .o_command(cmd), .o_pwm(pwm), .o_speed1(s1), .o_speed2(s2), .o_speed3(s3),
    .o_speed_percent(pct), .o_valve(valve), .o_send(send));
  rtc_actuator_model act_u (.i_clock(i_clock), .i_rst(i_rst), .i_send(send), .i_command(cmd),
    .i_speeds({s3, s2, s1}), .o_last_command(last_cmd), .o_last_speeds(last_spd));
  // ========
  // tasks
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check
  task automatic near(input string what, input int exp, input logic [7:0] got, input int tol);
    n_checks++;
    if ($isunknown(got) || int'(got) > exp + tol || int'(got) + tol < exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : near
  task automatic sample(input logic c, input int t, input int m);
    @(negedge i_clock);
    cool = c;
    tgt = 16'(t);
    meas = 16'(m);
    sv = 1'b1;
    @(negedge i_clock);
    sv = 1'b0;
    repeat (8) @(negedge i_clock);
  endtask : sample
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic wait_pwm(input logic lvl);
    for (cnt = 0; cnt < 2000 && pwm !== lvl; cnt++) @(negedge i_clock);
    if (cnt >= 2000) begin
      n_errors++;
      close_out();
    end
  endtask : wait_pwm
  task automatic check_idle();
    check("idle command", 8'h00, cmd);
    check("idle outputs", 8'h00, {2'h0, send, s3, s2, s1, valve, pwm});
    check("idle speed percent", 8'h00, pct);
  endtask : check_idle
  // ========
  // sequence
  initial begin
    repeat (10) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clock);
    check_idle();
    for (int k = 0; k < 5; k++) begin
      sample(pi_cool[k], 2000, pi_meas[k]);
      near("command", pi_exp[k], cmd, 1);
      near("sent command", pi_exp[k], last_cmd, 1);
    end
    bw = 16'h01f4;
    sample(1'b0, 2000, 1750);
    near("command wide band", 50, cmd, 1);
    bw = 16'h0190;
    sample(1'b0, 2000, 1800);
    wait_pwm(1'b0);
    wait_pwm(1'b1);
    cnt = 0;
    repeat (900) begin
      cnt += int'(pwm === 1'b1);
      @(negedge i_clock);
    end
    near("pwm on steps", 50, 8'(cnt / 9), 1);
    wait_pwm(1'b0);
    repeat (5) @(negedge i_clock);
    sample(1'b0, 2100, 1800);
    check("pwm restart", 8'h01, {7'h00, pwm});
    i_rst = 1'b1;
    ti = 16'h0001;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    @(negedge i_clock);
    check_idle();
    sample(1'b0, 2000, 1800);
    repeat (23) @(negedge i_clock);
    near("integral half", 75, cmd, 2);
    repeat (100) @(negedge i_clock);
    near("integral full", 100, cmd, 1);
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 7; k++) begin
        sample(c[0], 2000, c ? 2000 + fan_d[k] : 2000 - fan_d[k]);
        check("speeds", {5'h00, fan_s[k]}, {5'h00, s3, s2, s1});
        check("valve", {7'h00, fan_v[k]}, {7'h00, valve});
        check("speed percent", fan_p[k], pct);
        check("sent speeds", {5'h00, fan_s[k]}, {5'h00, last_spd});
      end
    end
    close_out();
  end
endmodule : rtc_control_tb
`default_nettype wire
